// file: hw/isp_pkg.sv
// constants shared by the loader command interpreter
package isp_pkg;
  // bytes of a write-request frame
  localparam logic [7:0] OP_ERASE = 8'h00;
  localparam logic [7:0] OP_START = 8'h03;
  localparam logic [7:0] ERASE_BLOCK0 = 8'h00;
  localparam logic [7:0] ERASE_BLOCK1 = 8'h20;
  localparam logic [7:0] ERASE_FULL = 8'hff;
  localparam logic [7:0] START_WATCHDOG = 8'h00;
  localparam logic [7:0] START_JUMP = 8'h01;
  localparam logic [3:0] LEN_ERASE = 4'h2;
  localparam logic [3:0] LEN_START_WDOG = 4'h2;
  localparam logic [3:0] LEN_START_JUMP = 4'h4;
  // reply frames: length 1, data byte 00h for both kinds
  localparam logic [3:0] REPLY_LEN = 4'h1;
  localparam logic [7:0] REPLY_DATA = 8'h00;
  // flash layout: 128 byte pages, two blocks of 64 pages
  localparam logic [6:0] BLOCK0_FIRST = 7'h00;
  localparam logic [6:0] BLOCK0_LAST = 7'h3f;
  localparam logic [6:0] BLOCK1_FIRST = 7'h40;
  localparam logic [6:0] BLOCK1_LAST = 7'h7f;
  localparam logic [7:0] CFG_ERASED = 8'hff;
  localparam logic [7:0] SSB_NO_SECURITY = 8'hff;
  // service selectors and configuration indices
  localparam logic [7:0] SVC_PROGRAM = 8'h0d;
  localparam logic [7:0] SVC_READ_CFG = 8'h05;
  localparam logic [7:0] SVC_READ_HSB = 8'h08;
  localparam logic [7:0] SVC_VERSION = 8'h0e;
  localparam logic [7:0] CFG_BSB = 8'h00;
  localparam logic [7:0] CFG_SBV = 8'h01;
  localparam logic [7:0] CFG_SSB = 8'h05;
  // parameter cells by index, byte address is four times the index
  localparam logic [7:0] IDX_SELECTOR = 8'h1c;
  localparam logic [7:0] IDX_VALUE = 8'h1d;
  localparam logic [7:0] IDX_PARAM_HI = 8'h1e;
  localparam logic [7:0] IDX_PARAM_LO = 8'h1f;
  localparam logic [7:0] ADDR_SELECTOR = 8'(IDX_SELECTOR * 8'h04);
  localparam logic [7:0] ADDR_VALUE = 8'(IDX_VALUE * 8'h04);
  localparam logic [7:0] ADDR_PARAM_HI = 8'(IDX_PARAM_HI * 8'h04);
  localparam logic [7:0] ADDR_PARAM_LO = 8'(IDX_PARAM_LO * 8'h04);
  localparam logic [7:0] ADDR_ENTRY = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam int ENTRY_CALL_BIT = 0;
  localparam int ENTRY_BOOT_EN_BIT = 1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_OPEN_BIT = 1;
  localparam int STAT_WDOG_BIT = 2;
  localparam logic [7:0] CELL_RESET = 8'h00;
endpackage : isp_pkg

// file: hw/isp_interp.sv
// loader command interpreter: erase, application start and local services
//
// Summary of operation
// - erase and start frames act only while communication is open
// - erase frame: length 2, byte0 00h; 00h block0, 20h block1, FFh full
// - full erase clears 16 Kbyte flash, then status, vector, security to FFh
// - block erase touches only 0000h-1FFFh or 2000h-3FFFh
// - block erase on protected chip gives error frame, else erase and ack
// - full erase ignores security and acks with length 1, byte 00h
// - full erase walks all 128 pages, busy until the last is done
// - frame 03h,00h length 2 enables watchdog then waits for its reset
// - frame length 4, byte1 01h jumps to address in bytes 2 and 3
// - neither start option sends a reply frame
// - security refusal sends error frame length 1, byte 00h, only code
// - caller cells: selector 1Ch, value 1Dh, high 1Eh, low 1Fh
// - selector 0Dh writes the latched flash byte or page
// - 05h reads config byte by low parameter, 08h security, 0Eh version
// - a finished read service leaves its byte in the value cell
`timescale 1ns/1ps
module isp_interp #(
  parameter logic [7:0] LOADER_VERSION = 8'h10,
  parameter logic [7:0] NV_RESET = 8'hff
) (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // avalon-mm slave
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // received frames, byte0 in bits 7:0
  input wire logic rx_valid_in,
  input wire logic rx_write_request_frame_in,
  input wire logic [3:0] rx_len_in,
  input wire logic [31:0] rx_data_in,
  output logic rx_ready_out,
  input wire logic comm_open_in,
  // reply frames
  output logic tx_valid_out,
  output logic tx_error_frame_out,
  output logic [3:0] tx_len_out,
  output logic [7:0] tx_data_out,
  // flash page erase and program
  output logic flash_erase_req_out,
  output logic [6:0] flash_page_out,
  output logic flash_prog_req_out,
  input wire logic flash_done_in,
  // configuration bytes held outside
  output logic [7:0] cfg_index_out,
  input wire logic [7:0] cfg_data_in,
  input wire logic [7:0] hardware_security_byte_in,
  // application start
  output logic watchdog_enable_out,
  output logic app_jump_out,
  output logic [15:0] app_jump_addr_out,
  output logic boot_memory_enable_out
);

  typedef enum logic [2:0] {
    ST_IDLE, ST_ERASE, ST_ERASE_WAIT, ST_PROG_WAIT, ST_PARKED
  } state_type;

  state_type state_q;
  logic [6:0] page_q;
  logic [6:0] last_q;
  logic full_q;
  logic [7:0] boot_status_byte_q;
  logic [7:0] software_boot_vector_q;
  logic [7:0] software_security_byte_q;
  logic [7:0] selector_q;
  logic [7:0] value_q;
  logic [7:0] param_hi_q;
  logic [7:0] param_lo_q;
  logic boot_en_q;
  logic rd_ack_q;
  logic [31:0] rdata_q;
  logic tx_valid_q;
  logic tx_error_q;
  logic erase_req_q;
  logic prog_req_q;
  logic wdog_q;
  logic jump_q;
  logic [15:0] jump_addr_q;

  logic busy;
  logic bus_take_wr;
  logic bus_take_rd;
  logic call;
  logic take;
  logic [7:0] b0;
  logic [7:0] b1;
  logic is_erase;
  logic is_blk0;
  logic is_blk1;
  logic is_full;
  logic is_wdog;
  logic is_jump;
  logic protected_chip;
  logic last_done;
  logic [7:0] cfg_byte;

  assign busy = (state_q != ST_IDLE);
  assign b0 = rx_data_in[7:0];
  assign b1 = rx_data_in[15:8];
  assign protected_chip =
    (software_security_byte_q != isp_pkg::SSB_NO_SECURITY);

  // bus side: writes and reads stall while busy, reads then take one more wait cycle
  assign bus_take_wr = avs_write_in & ~busy;
  assign bus_take_rd = avs_read_in & ~busy & ~rd_ack_q;
  assign avs_waitrequest_out = busy | (avs_read_in & ~rd_ack_q);
  assign call = bus_take_wr & (avs_address_in == isp_pkg::ADDR_ENTRY)
    & avs_writedata_in[isp_pkg::ENTRY_CALL_BIT];
  // a local call in the same cycle wins over a waiting frame
  assign rx_ready_out = ~busy & ~call;

  // frames count only while open; other frames are consumed silently
  assign take = rx_valid_in & rx_ready_out & rx_write_request_frame_in
    & comm_open_in;
  assign is_erase = take & (rx_len_in == isp_pkg::LEN_ERASE)
    & (b0 == isp_pkg::OP_ERASE);
  assign is_blk0 = is_erase & (b1 == isp_pkg::ERASE_BLOCK0);
  assign is_blk1 = is_erase & (b1 == isp_pkg::ERASE_BLOCK1);
  assign is_full = is_erase & (b1 == isp_pkg::ERASE_FULL);
  assign is_wdog = take & (rx_len_in == isp_pkg::LEN_START_WDOG)
    & (b0 == isp_pkg::OP_START) & (b1 == isp_pkg::START_WATCHDOG);
  assign is_jump = take & (rx_len_in == isp_pkg::LEN_START_JUMP)
    & (b0 == isp_pkg::OP_START) & (b1 == isp_pkg::START_JUMP);
  assign last_done = (state_q == ST_ERASE_WAIT) & flash_done_in
    & (page_q == last_q);

  always_comb begin
    case (param_lo_q)
      isp_pkg::CFG_BSB: cfg_byte = boot_status_byte_q;
      isp_pkg::CFG_SBV: cfg_byte = software_boot_vector_q;
      isp_pkg::CFG_SSB: cfg_byte = software_security_byte_q;
      default: cfg_byte = cfg_data_in;
    endcase
  end

  // sequencer; an unknown erase selector falls through and stays idle
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= ST_IDLE;
    end else begin
      case (state_q)
        ST_IDLE: begin
          if (is_full || ((is_blk0 || is_blk1) && !protected_chip)) begin
            state_q <= ST_ERASE;
          end else if (is_wdog) begin
            state_q <= ST_PARKED;
          end else if (call && selector_q == isp_pkg::SVC_PROGRAM) begin
            state_q <= ST_PROG_WAIT;
          end
        end
        ST_ERASE: state_q <= ST_ERASE_WAIT;
        ST_ERASE_WAIT: begin
          if (last_done) begin
            state_q <= ST_IDLE;
          end else if (flash_done_in) begin
            state_q <= ST_ERASE;
          end
        end
        ST_PROG_WAIT: begin
          if (flash_done_in) begin
            state_q <= ST_IDLE;
          end
        end
        // parked until the watchdog resets the whole chip
        ST_PARKED: state_q <= ST_PARKED;
        default: state_q <= ST_IDLE;
      endcase
    end
  end

  // page walk over the selected range
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      page_q <= isp_pkg::BLOCK0_FIRST;
      last_q <= isp_pkg::BLOCK0_LAST;
      full_q <= 1'b0;
    end else if (state_q == ST_IDLE && is_erase) begin
      page_q <= is_blk1 ? isp_pkg::BLOCK1_FIRST
        : isp_pkg::BLOCK0_FIRST;
      last_q <= is_blk0 ? isp_pkg::BLOCK0_LAST
        : isp_pkg::BLOCK1_LAST;
      full_q <= is_full;
    end else if (state_q == ST_ERASE_WAIT && flash_done_in && !last_done) begin
      page_q <= 7'(page_q + 7'h01);
    end
  end

  // nonvolatile configuration images
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      boot_status_byte_q <= NV_RESET;
      software_boot_vector_q <= NV_RESET;
      software_security_byte_q <= NV_RESET;
    end else if (last_done && full_q) begin
      boot_status_byte_q <= isp_pkg::CFG_ERASED;
      software_boot_vector_q <= isp_pkg::CFG_ERASED;
      software_security_byte_q <= isp_pkg::SSB_NO_SECURITY;
    end
  end

  // reply frames, a single-cycle pulse
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      tx_valid_q <= 1'b0;
      tx_error_q <= 1'b0;
    end else if (state_q == ST_IDLE && (is_blk0 || is_blk1)
        && protected_chip) begin
      tx_valid_q <= 1'b1;
      tx_error_q <= 1'b1;
    end else begin
      tx_valid_q <= last_done;
      tx_error_q <= 1'b0;
    end
  end

  // flash strobes
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      erase_req_q <= 1'b0;
      prog_req_q <= 1'b0;
    end else begin
      erase_req_q <= (state_q == ST_ERASE);
      prog_req_q <= (state_q == ST_IDLE) && call
        && (selector_q == isp_pkg::SVC_PROGRAM);
    end
  end

  // application start, neither option answers
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      wdog_q <= 1'b0;
      jump_q <= 1'b0;
      jump_addr_q <= 16'h0000;
    end else begin
      if (is_wdog) begin
        wdog_q <= 1'b1;
      end
      jump_q <= is_jump;
      if (is_jump) begin
        jump_addr_q <= {rx_data_in[23:16], rx_data_in[31:24]};
      end
    end
  end

  // parameter cells and entry register
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      selector_q <= isp_pkg::CELL_RESET;
      value_q <= isp_pkg::CELL_RESET;
      param_hi_q <= isp_pkg::CELL_RESET;
      param_lo_q <= isp_pkg::CELL_RESET;
      boot_en_q <= 1'b0;
    end else if (call) begin
      // after a program call (selector 0Dh) the caller is stalled on its next access until the write is done
      case (selector_q)
        isp_pkg::SVC_READ_CFG: value_q <= cfg_byte;
        isp_pkg::SVC_READ_HSB: value_q <= hardware_security_byte_in;
        isp_pkg::SVC_VERSION: value_q <= LOADER_VERSION;
        default: value_q <= value_q;
      endcase
      boot_en_q <= avs_writedata_in[isp_pkg::ENTRY_BOOT_EN_BIT];
    end else if (bus_take_wr) begin
      case (avs_address_in)
        isp_pkg::ADDR_SELECTOR: selector_q <= avs_writedata_in[7:0];
        isp_pkg::ADDR_VALUE: value_q <= avs_writedata_in[7:0];
        isp_pkg::ADDR_PARAM_HI: param_hi_q <= avs_writedata_in[7:0];
        isp_pkg::ADDR_PARAM_LO: param_lo_q <= avs_writedata_in[7:0];
        isp_pkg::ADDR_ENTRY:
          boot_en_q <= avs_writedata_in[isp_pkg::ENTRY_BOOT_EN_BIT];
        default: boot_en_q <= boot_en_q;
      endcase
    end
  end

  // read data is registered, hence the single wait cycle
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_ack_q <= 1'b0;
      rdata_q <= 32'h00000000;
    end else begin
      rd_ack_q <= bus_take_rd;
      if (bus_take_rd) begin
        case (avs_address_in)
          isp_pkg::ADDR_SELECTOR: rdata_q <= {24'h000000, selector_q};
          isp_pkg::ADDR_VALUE: rdata_q <= {24'h000000, value_q};
          isp_pkg::ADDR_PARAM_HI: rdata_q <= {24'h000000, param_hi_q};
          isp_pkg::ADDR_PARAM_LO: rdata_q <= {24'h000000, param_lo_q};
          isp_pkg::ADDR_ENTRY: rdata_q <= {30'h00000000, boot_en_q, 1'b0};
          isp_pkg::ADDR_STATUS:
            rdata_q <= {29'h00000000, wdog_q, comm_open_in, busy};
          default: rdata_q <= 32'h00000000;
        endcase
      end
    end
  end

  assign avs_readdata_out = rdata_q;
  assign tx_valid_out = tx_valid_q;
  assign tx_error_frame_out = tx_error_q;
  assign tx_len_out = isp_pkg::REPLY_LEN;
  assign tx_data_out = isp_pkg::REPLY_DATA;
  assign flash_erase_req_out = erase_req_q;
  assign flash_page_out = page_q;
  assign flash_prog_req_out = prog_req_q;
  assign cfg_index_out = param_lo_q;
  assign watchdog_enable_out = wdog_q;
  assign app_jump_out = jump_q;
  assign app_jump_addr_out = jump_addr_q;
  assign boot_memory_enable_out = boot_en_q;

  sequence start_block1_s;
    is_blk1 && !protected_chip && !busy;
  endsequence

  sequence first_erase_s(logic [6:0] pg);
    flash_erase_req_out && flash_page_out == pg;
  endsequence

  // a program call in the same cycle legitimately goes busy
  closed_ignored_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (rx_valid_in && !comm_open_in && !busy && !call)
    |=> !busy && !tx_valid_out)
    else $error("frame acted on while communication closed");
  block1_range_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    start_block1_s |=> ##1 first_erase_s(7'h40))
    else $error("block one erase does not start at page 64");
  block0_range_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    flash_erase_req_out && !full_q && last_q == 7'h3f
    |-> page_q <= 7'h3f)
    else $error("block zero erase left its range");
  protect_error_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    (is_blk0 || is_blk1) && protected_chip && !busy
    |=> tx_valid_out && tx_error_frame_out && !busy)
    else $error("protected block erase did not give error frame");
  full_runs_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    is_full && !busy |=> ##1 first_erase_s(7'h00))
    else $error("full erase did not start at page zero");
  full_config_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    tx_valid_out && !tx_error_frame_out && full_q
    |-> software_security_byte_q == 8'hff && boot_status_byte_q == 8'hff
    && software_boot_vector_q == 8'hff)
    else $error("config bytes not erased on full erase ack");
  ack_after_last_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    tx_valid_out && !tx_error_frame_out
    |-> $past(state_q) == ST_ERASE_WAIT && $past(page_q) == last_q)
    else $error("ack sent before the last page was done");
  busy_erase_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    flash_erase_req_out |-> !rx_ready_out ##1 !rx_ready_out)
    else $error("frame accepted during erase");
  wdog_park_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    is_wdog && !busy |=> watchdog_enable_out && !tx_valid_out
    ##1 (watchdog_enable_out && !rx_ready_out)[*3])
    else $error("watchdog start not held or answered");
  jump_addr_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    is_jump |=> app_jump_out && !tx_valid_out
    && app_jump_addr_out[15:8] == $past(rx_data_in[23:16])
    && app_jump_addr_out[7:0] == $past(rx_data_in[31:24]))
    else $error("jump address or reply wrong");
  unknown_erase_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    is_erase && !is_blk0 && !is_blk1 && !is_full && !busy
    |=> !busy && !tx_valid_out)
    else $error("unknown erase selector acted on");
  prog_strobe_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    call && selector_q == 8'h0d |=> flash_prog_req_out && busy)
    else $error("program service did not strobe flash");
  hsb_value_a: assert property (
    @(posedge clk_in) disable iff (!rst_n_in)
    call && selector_q == 8'h08
    |=> value_q == $past(hardware_security_byte_in))
    else $error("security byte not returned in value cell");

endmodule : isp_interp

// file: test/flash_model.sv
// flash array stand-in: finishes each page erase or write after a delay
`timescale 1ns/1ps
module flash_model (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // requests from the interpreter
  input wire logic erase_req_in,
  input wire logic prog_req_in,
  input wire logic [3:0] delay_in,
  // completion pulse
  output logic done_out
);
  logic [3:0] wait_q;
  logic busy_q;
  // delay is taken per request so prompt and slow answers both occur
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      busy_q <= 1'b0;
      wait_q <= 4'h0;
    end else if (!busy_q && (erase_req_in || prog_req_in)) begin
      busy_q <= 1'b1;
      wait_q <= delay_in;
    end else if (busy_q && wait_q == 4'h0) begin
      busy_q <= 1'b0;
    end else if (busy_q) begin
      wait_q <= wait_q - 4'h1;
    end
  end
  assign done_out = busy_q && wait_q == 4'h0;
endmodule : flash_model

// file: test/can_isp_erase_start_api_interp_bench.sv
// self-checking bench for the loader command interpreter
`timescale 1ns/1ps
module can_isp_erase_start_api_interp_bench;
  logic clk_in, rst_n_in, rd, wr, waitreq, rx_valid, rx_wrf, rx_ready;
  logic comm_open, tx_valid, tx_err, erase_req, prog_req, done;
  logic wdog, jump, boot_en;
  logic [7:0] addr, cfg_index, cfg_data, hardware_security_byte, tx_data;
  logic [31:0] wdata, rdata, rx_data, rd_got;
  logic [3:0] rx_len, tx_len, delay;
  logic [6:0] page;
  logic [15:0] jump_addr;
  logic tx_q[$];
  logic [6:0] page_q[$];
  logic [15:0] jump_q[$];
  logic [31:0] rd_q[$];
  int err_count, compares, prog_n, cycles, seed;
  event rd_ev;

  isp_interp #(.LOADER_VERSION(8'h10), .NV_RESET(8'h00)) u_isp_interp (
    .clk_in(clk_in), .rst_n_in(rst_n_in),
    .avs_address_in(addr), .avs_read_in(rd), .avs_write_in(wr),
    .avs_writedata_in(wdata), .avs_readdata_out(rdata),
    .avs_waitrequest_out(waitreq),
    .rx_valid_in(rx_valid), .rx_write_request_frame_in(rx_wrf),
    .rx_len_in(rx_len), .rx_data_in(rx_data), .rx_ready_out(rx_ready),
    .comm_open_in(comm_open),
    .tx_valid_out(tx_valid), .tx_error_frame_out(tx_err),
    .tx_len_out(tx_len), .tx_data_out(tx_data),
    .flash_erase_req_out(erase_req), .flash_page_out(page),
    .flash_prog_req_out(prog_req), .flash_done_in(done),
    .cfg_index_out(cfg_index), .cfg_data_in(cfg_data),
    .hardware_security_byte_in(hardware_security_byte),
    .watchdog_enable_out(wdog), .app_jump_out(jump),
    .app_jump_addr_out(jump_addr), .boot_memory_enable_out(boot_en));

  flash_model u_flash_model (.clk_in(clk_in), .rst_n_in(rst_n_in),
    .erase_req_in(erase_req), .prog_req_in(prog_req),
    .delay_in(delay), .done_out(done));

  task automatic chk(input string n, input logic [31:0] e,
                     input logic [31:0] g);
    compares++;
    if (e !== g) begin
      $display("mismatch %s expected %h seen %h", n, e, g);
      err_count++;
    end
  endtask : chk

  task automatic results;
    if (err_count == 0 && compares > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : results

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_in);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_in);
    while (waitreq !== 1'b0) @(posedge clk_in);
    wr <= 1'b0;
    wdata <= ~d;
  endtask : bus_wr

  task automatic bus_rd(input logic [7:0] a, input logic [31:0] e);
    rd_q.push_back(e);
    @(posedge clk_in);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_in);
    while (waitreq !== 1'b0) @(posedge clk_in);
    rd_got = rdata;
    rd <= 1'b0;
    -> rd_ev;
  endtask : bus_rd

  // frame data is scrambled once released, as a real link would
  task automatic send(input logic w, input logic [3:0] n,
                      input logic [31:0] d);
    @(posedge clk_in);
    rx_wrf <= w;
    rx_len <= n;
    rx_data <= d;
    rx_valid <= 1'b1;
    @(posedge clk_in);
    while (rx_ready !== 1'b1) @(posedge clk_in);
    rx_valid <= 1'b0;
    rx_data <= ~d;
  endtask : send

  // a status read stalls while busy, so it also waits for completion
  task automatic idle(input logic o);
    bus_rd(isp_pkg::ADDR_STATUS, {30'h0, o, 1'b0});
  endtask : idle

  task automatic svc(input logic [7:0] s, input logic [7:0] lo,
                     input logic [7:0] e);
    bus_wr(isp_pkg::ADDR_SELECTOR, {24'h0, s});
    bus_wr(isp_pkg::ADDR_PARAM_LO, {24'h0, lo});
    // the bench has no interrupts or eeprom to mask around the call
    bus_wr(isp_pkg::ADDR_ENTRY, 32'h3);
    bus_rd(isp_pkg::ADDR_VALUE, {24'h0, e});
  endtask : svc

  task automatic erase(input logic [7:0] s, input logic [6:0] f,
                       input int n, input logic er);
    for (int i = 0; i < n; i++) page_q.push_back(7'(f + i));
    tx_q.push_back(er);
    send(1'b1, 4'h2, {16'h0, s, 8'h00});
    idle(1'b1);
  endtask : erase

  initial begin
    clk_in = 1'b0;
    forever #20 clk_in = ~clk_in;
  end

  always @(posedge clk_in) begin
    delay <= 4'($random(seed));
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      results();
    end
  end

  // result watcher: oldest expectation against what appears
  always @(posedge clk_in) begin
    if (tx_valid === 1'b1) begin
      chk("tx_expected", 1, tx_q.size() > 0);
      if (tx_q.size() > 0) chk("tx_error", tx_q.pop_front(), tx_err);
      chk("tx_len", 4'h1, tx_len);
      chk("tx_data", 8'h00, tx_data);
    end
    if (erase_req === 1'b1) begin
      chk("erase_expected", 1, page_q.size() > 0);
      if (page_q.size() > 0) chk("page", page_q.pop_front(), page);
    end
    if (prog_req === 1'b1) begin
      chk("prog_expected", 1, prog_n > 0);
      prog_n--;
    end
    if (jump === 1'b1) begin
      chk("jump_expected", 1, jump_q.size() > 0);
      if (jump_q.size() > 0) begin
        chk("jump_addr", jump_q.pop_front(), jump_addr);
      end
    end
  end

  always @(rd_ev) chk("readdata", rd_q.pop_front(), rd_got);

  initial begin
    seed = 71112;
    {rst_n_in, rd, wr, rx_valid, rx_wrf, comm_open} = 6'h0;
    {addr, cfg_data, hardware_security_byte, wdata, rx_data, rx_len} = '0;
    repeat (20) @(posedge clk_in);
    rst_n_in <= 1'b1;
    bus_rd(8'h40, 32'h0);
    send(1'b1, 4'h2, 32'h0);
    idle(1'b0);
    comm_open <= 1'b1;
    tx_q.push_back(1'b1);
    send(1'b1, 4'h2, 32'h0);
    idle(1'b1);
    send(1'b1, 4'h2, 32'h5500);
    send(1'b0, 4'h2, 32'h0000);
    idle(1'b1);
    svc(isp_pkg::SVC_READ_CFG, 8'h00, 8'h00);
    svc(isp_pkg::SVC_READ_CFG, 8'h05, 8'h00);
    erase(8'hff, 7'h00, 128, 1'b0);
    svc(isp_pkg::SVC_READ_CFG, 8'h00, 8'hff);
    svc(isp_pkg::SVC_READ_CFG, 8'h01, 8'hff);
    svc(isp_pkg::SVC_READ_CFG, 8'h05, 8'hff);
    erase(8'h20, 7'h40, 64, 1'b0);
    erase(8'h00, 7'h00, 64, 1'b0);
    cfg_data <= 8'($random(seed));
    hardware_security_byte <= 8'($random(seed));
    @(posedge clk_in);
    svc(isp_pkg::SVC_READ_CFG, 8'h30, cfg_data);
    chk("cfg_index", 8'h30, cfg_index);
    svc(isp_pkg::SVC_READ_HSB, 8'h00, hardware_security_byte);
    svc(isp_pkg::SVC_VERSION, 8'h00, 8'h10);
    prog_n = 1;
    bus_wr(isp_pkg::ADDR_SELECTOR, {24'h0, isp_pkg::SVC_PROGRAM});
    bus_wr(isp_pkg::ADDR_ENTRY, 32'h3);
    idle(1'b1);
    chk("boot_enable", 1'b1, boot_en);
    jump_q.push_back(16'h1234);
    send(1'b1, 4'h4, 32'h34120103);
    idle(1'b1);
    send(1'b1, 4'h2, 32'h0003);
    repeat (10) @(posedge clk_in);
    chk("watchdog", 1'b1, wdog);
    chk("left", 0, tx_q.size() + page_q.size() + jump_q.size() + prog_n);
    results();
  end
endmodule : can_isp_erase_start_api_interp_bench
